// *** sdp_pkg.sv ***
// Constants, register map and carrier types of the slow-down and S-curve profile block
package sdp_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STEP_W = 14;
  localparam int RATE_W = 16;
  localparam int MAG_W = 12;
  localparam int SDP_W = 24;
  localparam int SCW_W = 13;
  localparam int CNT_W = 32;
  localparam int IVL_W = RATE_W + 1;

  // Register word addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FEED = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LOW = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_HIGH = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_ACC = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DEC = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MAG = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SDP = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_ASW = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_DSW = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_REM = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_CUR = 8'h30;

  // Control word fields
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_METHOD = 4;
  localparam int CTRL_SHAPE = 5;
  localparam int CTRL_TRI = 6;

  // Status word fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_PHASE = 4;

  // Reset values of the settings
  localparam logic [STEP_W-1:0] RST_STEP = 14'h0001;
  localparam logic [RATE_W-1:0] RST_ACC = 16'h0001;
  localparam logic [MAG_W-1:0] RST_MAG = 12'h001;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ACCEL,
    PH_CRUISE,
    PH_DECEL,
    PH_TAIL
  } sdp_phase_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sdp_bus_req_t;

  typedef struct packed {
    logic [STEP_W-1:0] low_step;
    logic [STEP_W-1:0] high_step;
    logic [RATE_W-1:0] accel_rate;
    logic [RATE_W-1:0] decel_rate;
    logic [MAG_W-1:0] magnification;
    logic [SDP_W-1:0] slow_down_point;
    logic [SCW_W-1:0] accel_scurve_width;
    logic [SCW_W-1:0] decel_scurve_width;
    logic slowdown_method_select;
    logic curve_shape_select;
    logic triangle_avoid_disable;
  } sdp_cfg_t;

  typedef struct packed {
    sdp_cfg_t pre;
    sdp_cfg_t work;
    logic [CNT_W-1:0] feed_pre;
    logic [CNT_W-1:0] remaining_pulse_count;
    logic [CNT_W-1:0] accel_pulses;
    sdp_phase_t phase;
    logic [STEP_W-1:0] cur_step;
    logic [STEP_W-1:0] frac;
    logic [STEP_W-1:0] slope;
    logic [IVL_W-1:0] ivl;
    logic pulse;
    logic busy;
    logic [DATA_W-1:0] rdata;
  } sdp_state_t;

  typedef struct packed {
    logic [MAG_W-1:0] div_cnt;
    logic [STEP_W-1:0] acc;
    logic pulse;
  } sdp_gen_state_t;

endpackage : sdp_pkg

// *** sdp_rate_gen.sv ***
// Pulse rate generator: step times clock over (magnification plus one) times 16384
`timescale 1ns/10ps
module sdp_rate_gen (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [sdp_pkg::STEP_W-1:0] step,
  input wire logic [sdp_pkg::MAG_W-1:0] mag,
  output logic pulse
);

  sdp_pkg::sdp_gen_state_t s_q;
  sdp_pkg::sdp_gen_state_t s_d;
  logic [sdp_pkg::STEP_W:0] sum;

  assign sum = {1'b0, s_q.acc} + {1'b0, step};

  always_comb begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (!run) begin
      s_d = '0;
    end else if (s_q.div_cnt == mag) begin
      // Carry out of the 14-bit phase word is one output pulse (R19) (R18)
      s_d.div_cnt = '0;
      s_d.acc = sum[sdp_pkg::STEP_W-1:0];
      s_d.pulse = sum[sdp_pkg::STEP_W];
    end else begin
      s_d.div_cnt = s_q.div_cnt + 12'h001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse = s_q.pulse;

  a_pulse_on_tick: assert property (@(posedge clk) disable iff (reset)
    s_q.pulse |-> $past(run) && $past(s_q.div_cnt) == $past(mag)) // R19
    else $error("pulse outside a divider tick");

endmodule : sdp_rate_gen

// *** sdp_profile.sv ***
// Slow-down point and S-curve acceleration profile of one pulse axis
//
// Contract
// (R1) Automatic mode: positive signed offset starts deceleration earlier, then low-speed run.
// (R2) Automatic mode: negative offset delays deceleration, stopping above starting speed.
// (R3) Host writes zero offset when no shift of automatic point is wanted.
// (R4) Manual mode: decelerate once remaining pulses drop below slow-down point.
// (R5) Host disables triangle avoidance whenever manual slow-down is selected.
// (R6) Host computes linear ideal point from steps, decel rate, magnification.
// (R7) Host doubles linear ideal point for full S-curve deceleration.
// (R8) Host computes partial S-curve ideal point including twice section width.
// (R9) Manual point above ideal runs low speed; below ideal stops early.
// (R10) Acceleration curve width is register value in speed-step units.
// (R11) S acceleration curves near both ends, linear between them.
// (R12) Zero acceleration width gives full curve of half step difference.
// (R13) Deceleration curve width is register value in speed-step units.
// (R14) S deceleration curves near both ends, linear between them.
// (R15) Zero deceleration width gives full curve of half step difference.
// (R16) Zero deceleration rate reuses acceleration rate.
// (R17) Host writes pre-registers; working copies are loaded at start.
// (R18) Top rate reached with magnification one and step 16383.
// (R19) Pulse rate equals step times clock over (mag+1) times 16384.
// (R20) Shape bit clear gives linear ramps, set gives S-curve ramps.
// (R21) Threshold compared on every output pulse; deceleration begins on that pulse.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/10ps
module sdp_profile (
  input wire logic clk,
  input wire logic reset,
  input sdp_pkg::sdp_bus_req_t bus_req,
  output logic [sdp_pkg::DATA_W-1:0] bus_rdata,
  output logic pulse_out,
  output logic busy
);

  sdp_pkg::sdp_state_t s_q;
  sdp_pkg::sdp_state_t s_d;

  logic gen_pulse;
  logic run;
  logic ramping;
  logic is_decel;
  logic [sdp_pkg::RATE_W-1:0] eff_decel_rate;
  logic [sdp_pkg::RATE_W-1:0] rate_sel;
  logic ivl_end;
  logic [sdp_pkg::STEP_W-1:0] span;
  logic [sdp_pkg::SCW_W-1:0] width_reg;
  logic [sdp_pkg::STEP_W-1:0] width;
  logic lin;
  logic [sdp_pkg::STEP_W-1:0] d_lo;
  logic [sdp_pkg::STEP_W-1:0] d_hi;
  logic [sdp_pkg::STEP_W-1:0] d_in;
  logic [sdp_pkg::STEP_W-1:0] d_out;
  logic [sdp_pkg::STEP_W-1:0] w2;
  logic [sdp_pkg::STEP_W-1:0] slope_nx;
  logic [sdp_pkg::STEP_W:0] frac_sum;
  logic frac_hit;
  logic step_now;
  logic [sdp_pkg::CNT_W-1:0] rem_next;
  logic signed [sdp_pkg::CNT_W+1:0] auto_thr;
  logic decel_hit;
  logic start_cmd;
  logic stop_cmd;

  assign run = s_q.phase != sdp_pkg::PH_IDLE;
  assign ramping = s_q.phase == sdp_pkg::PH_ACCEL || s_q.phase == sdp_pkg::PH_DECEL;
  assign is_decel = s_q.phase == sdp_pkg::PH_DECEL;

  sdp_rate_gen u_gen (
    .clk(clk),
    .reset(reset),
    .run(run),
    .step(s_q.cur_step),
    .mag(s_q.work.magnification),
    .pulse(gen_pulse)
  );

  // One ramp interval every 2*(rate+1) clocks; a linear ramp takes one speed step per interval
  assign eff_decel_rate = (s_q.work.decel_rate == '0) ?
                          s_q.work.accel_rate : s_q.work.decel_rate; // R16
  assign rate_sel = is_decel ? eff_decel_rate : s_q.work.accel_rate;
  assign ivl_end = ramping && (s_q.ivl == {rate_sel, 1'b1});

  // Curve width in speed steps; zero means half the ramp span
  assign span = s_q.work.high_step - s_q.work.low_step;
  assign width_reg = is_decel ? s_q.work.decel_scurve_width :
                     s_q.work.accel_scurve_width; // R10 R13
  assign width = (width_reg == '0) ? {1'b0, span[sdp_pkg::STEP_W-1:1]} :
                 {1'b0, width_reg}; // R12 R15
  assign lin = !s_q.work.curve_shape_select || width == '0; // R20

  // Distances from the end the ramp leaves and the end it heads for
  assign d_lo = (s_q.cur_step > s_q.work.low_step) ?
                s_q.cur_step - s_q.work.low_step : '0;
  assign d_hi = (s_q.work.high_step > s_q.cur_step) ?
                s_q.work.high_step - s_q.cur_step : '0;
  assign d_in = is_decel ? d_hi : d_lo;
  assign d_out = is_decel ? d_lo : d_hi;
  assign w2 = {width[sdp_pkg::STEP_W-2:0], 1'b0};
  // Slope in units of 1/(2*width) steps per interval; full slope is one step
  assign frac_sum = {1'b0, s_q.frac} + {1'b0, s_q.slope};
  assign frac_hit = frac_sum >= {1'b0, w2};
  assign step_now = ivl_end && (lin || frac_hit); // R11 R14

  // Slope ramps by one unit per interval, so a curve takes twice the linear time
  always_comb begin
    slope_nx = w2;
    if (d_out <= width) begin
      // Floor of one keeps the last steps of a curve from stalling
      slope_nx = (s_q.slope > 14'h0001) ? s_q.slope - 14'h0001 : 14'h0001; // R11 R14
    end else if (d_in < width && s_q.slope < w2) begin
      slope_nx = s_q.slope + 14'h0001; // R11 R14
    end
  end

  assign rem_next = s_q.remaining_pulse_count - 32'h0000_0001;
  assign auto_thr = $signed({2'b00, s_q.accel_pulses}) +
                    {{10{s_q.work.slow_down_point[sdp_pkg::SDP_W-1]}},
                     $signed(s_q.work.slow_down_point)}; // R1 R2
  always_comb begin
    decel_hit = 1'b0;
    if (s_q.work.slowdown_method_select) begin
      decel_hit = rem_next < {8'h00, s_q.work.slow_down_point}; // R4 R9
    end else begin
      decel_hit = $signed({2'b00, rem_next}) <= auto_thr; // R1 R2
    end
  end

  assign start_cmd = bus_req.wr && bus_req.addr == sdp_pkg::OFS_CTRL &&
                     bus_req.wdata[sdp_pkg::CTRL_START];
  assign stop_cmd = bus_req.wr && bus_req.addr == sdp_pkg::OFS_CTRL &&
                    bus_req.wdata[sdp_pkg::CTRL_STOP];

  always_comb begin
    s_d = s_q;
    s_d.pulse = gen_pulse && run;
    s_d.rdata = '0;

    if (bus_req.rd) begin
      unique case (bus_req.addr)
        sdp_pkg::OFS_CTRL: s_d.rdata = {25'h0, s_q.pre.triangle_avoid_disable,
                                        s_q.pre.curve_shape_select,
                                        s_q.pre.slowdown_method_select, 4'h0};
        sdp_pkg::OFS_FEED: s_d.rdata = s_q.feed_pre;
        sdp_pkg::OFS_LOW: s_d.rdata = {18'h0, s_q.pre.low_step};
        sdp_pkg::OFS_HIGH: s_d.rdata = {18'h0, s_q.pre.high_step};
        sdp_pkg::OFS_ACC: s_d.rdata = {16'h0, s_q.pre.accel_rate};
        sdp_pkg::OFS_DEC: s_d.rdata = {16'h0, s_q.pre.decel_rate};
        sdp_pkg::OFS_MAG: s_d.rdata = {20'h0, s_q.pre.magnification};
        sdp_pkg::OFS_SDP: s_d.rdata = {8'h0, s_q.pre.slow_down_point};
        sdp_pkg::OFS_ASW: s_d.rdata = {19'h0, s_q.pre.accel_scurve_width};
        sdp_pkg::OFS_DSW: s_d.rdata = {19'h0, s_q.pre.decel_scurve_width};
        sdp_pkg::OFS_STAT: s_d.rdata = {25'h0, s_q.phase, 3'h0, s_q.busy};
        sdp_pkg::OFS_REM: s_d.rdata = s_q.remaining_pulse_count;
        sdp_pkg::OFS_CUR: s_d.rdata = {18'h0, s_q.cur_step};
        default: s_d.rdata = '0;
      endcase
    end

    // Host only ever touches the pre-registers (R17)
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        sdp_pkg::OFS_CTRL: begin
          s_d.pre.slowdown_method_select = bus_req.wdata[sdp_pkg::CTRL_METHOD];
          s_d.pre.curve_shape_select = bus_req.wdata[sdp_pkg::CTRL_SHAPE];
          s_d.pre.triangle_avoid_disable = bus_req.wdata[sdp_pkg::CTRL_TRI];
        end
        sdp_pkg::OFS_FEED: s_d.feed_pre = bus_req.wdata;
        sdp_pkg::OFS_LOW: s_d.pre.low_step = bus_req.wdata[sdp_pkg::STEP_W-1:0];
        sdp_pkg::OFS_HIGH: s_d.pre.high_step = bus_req.wdata[sdp_pkg::STEP_W-1:0];
        sdp_pkg::OFS_ACC: s_d.pre.accel_rate = bus_req.wdata[sdp_pkg::RATE_W-1:0];
        sdp_pkg::OFS_DEC: s_d.pre.decel_rate = bus_req.wdata[sdp_pkg::RATE_W-1:0];
        sdp_pkg::OFS_MAG: s_d.pre.magnification = bus_req.wdata[sdp_pkg::MAG_W-1:0];
        sdp_pkg::OFS_SDP: s_d.pre.slow_down_point = bus_req.wdata[sdp_pkg::SDP_W-1:0];
        sdp_pkg::OFS_ASW: s_d.pre.accel_scurve_width = bus_req.wdata[sdp_pkg::SCW_W-1:0];
        sdp_pkg::OFS_DSW: s_d.pre.decel_scurve_width = bus_req.wdata[sdp_pkg::SCW_W-1:0];
        default: begin
        end
      endcase
    end

    // Ramp stepping
    if (ramping) begin
      s_d.ivl = ivl_end ? '0 : s_q.ivl + 17'h0_0001;
    end else begin
      s_d.ivl = '0;
    end
    if (ivl_end && !lin) begin
      s_d.frac = frac_hit ? frac_sum[sdp_pkg::STEP_W-1:0] - w2 :
                 frac_sum[sdp_pkg::STEP_W-1:0];
      s_d.slope = slope_nx;
    end
    if (s_q.phase == sdp_pkg::PH_ACCEL) begin
      if (s_q.cur_step >= s_q.work.high_step) begin
        s_d.phase = sdp_pkg::PH_CRUISE;
      end else if (step_now) begin
        s_d.cur_step = s_q.cur_step + 14'h0001; // R11
        if (s_d.cur_step == s_q.work.high_step) begin
          s_d.phase = sdp_pkg::PH_CRUISE;
        end
      end
    end
    if (s_q.phase == sdp_pkg::PH_DECEL) begin
      if (s_q.cur_step <= s_q.work.low_step) begin
        s_d.phase = sdp_pkg::PH_TAIL;
      end else if (step_now) begin
        s_d.cur_step = s_q.cur_step - 14'h0001; // R14
        if (s_d.cur_step == s_q.work.low_step) begin
          s_d.phase = sdp_pkg::PH_TAIL;
        end
      end
    end

    // Every output pulse is counted; in acceleration and cruise it is also checked against the slow-down point
    if (gen_pulse && run) begin
      s_d.remaining_pulse_count = rem_next;
      if (s_q.phase == sdp_pkg::PH_ACCEL) begin
        s_d.accel_pulses = s_q.accel_pulses + 32'h0000_0001;
      end
      if (rem_next == '0) begin
        s_d.phase = sdp_pkg::PH_IDLE; // R9
      end else if ((s_q.phase == sdp_pkg::PH_ACCEL ||
                    s_q.phase == sdp_pkg::PH_CRUISE) && decel_hit) begin
        s_d.phase = sdp_pkg::PH_DECEL; // R21
        s_d.frac = '0;
        s_d.slope = '0;
        s_d.ivl = '0;
      end
    end

    if (stop_cmd) begin
      s_d.phase = sdp_pkg::PH_IDLE;
    end else if (start_cmd && !run && s_q.feed_pre != '0) begin
      // Working copies are loaded from the pre-registers at start (R17)
      s_d.work = s_q.pre;
      s_d.remaining_pulse_count = s_q.feed_pre;
      s_d.accel_pulses = '0;
      s_d.cur_step = s_q.pre.low_step;
      s_d.frac = '0;
      s_d.slope = '0;
      s_d.ivl = '0;
      s_d.phase = (s_q.pre.high_step > s_q.pre.low_step) ?
                  sdp_pkg::PH_ACCEL : sdp_pkg::PH_CRUISE;
    end
    if (s_d.phase == sdp_pkg::PH_IDLE) begin
      s_d.frac = '0;
      s_d.slope = '0;
    end
    s_d.busy = s_d.phase != sdp_pkg::PH_IDLE;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.pre.low_step <= sdp_pkg::RST_STEP;
      s_q.pre.high_step <= sdp_pkg::RST_STEP;
      s_q.pre.accel_rate <= sdp_pkg::RST_ACC;
      s_q.pre.magnification <= sdp_pkg::RST_MAG;
      s_q.phase <= sdp_pkg::PH_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata = s_q.rdata;
  assign pulse_out = s_q.pulse;
  assign busy = s_q.busy;

  sequence s_hit_manual;
    gen_pulse && run && s_q.work.slowdown_method_select && rem_next != '0 &&
    rem_next < {8'h00, s_q.work.slow_down_point} && !stop_cmd;
  endsequence

  sequence s_hit_auto;
    gen_pulse && run && !s_q.work.slowdown_method_select && rem_next != '0 &&
    $signed({2'b00, rem_next}) <= auto_thr && !stop_cmd;
  endsequence

  a_manual_decel_start: assert property (@(posedge clk) disable iff (reset) // R4
    s_hit_manual and (s_q.phase == sdp_pkg::PH_CRUISE) |=> s_q.phase == sdp_pkg::PH_DECEL)
    else $error("manual slow-down point missed");

  a_auto_decel_start: assert property (@(posedge clk) disable iff (reset) // R1
    s_hit_auto and (s_q.phase == sdp_pkg::PH_CRUISE) |=> s_q.phase == sdp_pkg::PH_DECEL)
    else $error("automatic slow-down point missed");

  a_no_early_decel: assert property (@(posedge clk) disable iff (reset) // R21
    s_q.phase == sdp_pkg::PH_CRUISE && !gen_pulse |=> s_q.phase != sdp_pkg::PH_DECEL)
    else $error("deceleration began without an output pulse");

  a_decel_rate_share: assert property (@(posedge clk) disable iff (reset) // R16
    is_decel && s_q.work.decel_rate == '0 |-> s_q.ivl <= {s_q.work.accel_rate, 1'b1})
    else $error("decel interval exceeds shared rate");

  a_linear_accel_step: assert property (@(posedge clk) disable iff (reset) // R20
    s_q.phase == sdp_pkg::PH_ACCEL && !s_q.work.curve_shape_select && ivl_end &&
    s_q.cur_step < s_q.work.high_step && !stop_cmd
    |=> s_q.cur_step == $past(s_q.cur_step) + 14'h0001)
    else $error("linear ramp missed a step");

  a_step_in_band: assert property (@(posedge clk) disable iff (reset) // R11
    s_q.phase == sdp_pkg::PH_CRUISE |-> s_q.cur_step == s_q.work.high_step ||
    s_q.work.high_step <= s_q.work.low_step)
    else $error("cruise below running speed");

  a_tail_at_low: assert property (@(posedge clk) disable iff (reset) // R14
    s_q.phase == sdp_pkg::PH_TAIL |-> s_q.cur_step == s_q.work.low_step)
    else $error("low-speed tail not at starting speed");

  a_scurve_slow_edge: assert property (@(posedge clk) disable iff (reset) // R12
    s_q.phase == sdp_pkg::PH_ACCEL && s_q.work.curve_shape_select && ivl_end &&
    s_q.cur_step == s_q.work.low_step && s_q.frac == '0 && width > 14'h0001 && !stop_cmd
    |=> s_q.cur_step == $past(s_q.cur_step))
    else $error("S-curve start not curved");

  a_slope_bounded: assert property (@(posedge clk) disable iff (reset) // R11
    ramping && !lin |-> s_q.slope <= w2)
    else $error("curve slope above full slope");

  a_decel_curve_rest: assert property (@(posedge clk) disable iff (reset) // R14
    $rose(is_decel) |-> s_q.slope == '0 && s_q.frac == '0)
    else $error("deceleration curve did not start at rest");

  a_full_slope_step: assert property (@(posedge clk) disable iff (reset) // R11
    ramping && !lin && ivl_end && s_q.slope == w2 |-> step_now)
    else $error("linear section missed a step");

  a_linear_decel_step: assert property (@(posedge clk) disable iff (reset) // R20
    is_decel && !s_q.work.curve_shape_select && ivl_end &&
    s_q.cur_step > s_q.work.low_step && !stop_cmd
    |=> s_q.cur_step == $past(s_q.cur_step) - 14'h0001)
    else $error("linear deceleration missed a step");

  a_start_loads_work: assert property (@(posedge clk) disable iff (reset) // R17
    start_cmd && !stop_cmd && !run && s_q.feed_pre != '0
    |=> s_q.work == $past(s_q.pre) && busy)
    else $error("working copy not loaded at start");

  a_stop_at_zero: assert property (@(posedge clk) disable iff (reset) // R9
    gen_pulse && run && s_q.remaining_pulse_count == 32'h0000_0001
    |=> s_q.phase == sdp_pkg::PH_IDLE ##1 !pulse_out)
    else $error("axis kept running after last pulse");

endmodule : sdp_profile

// *** sdp_host_model.sv ***
// Host model that loads the profile pre-registers over the register port
`timescale 1ns/10ps
module sdp_host_model (
  input wire logic clk,
  output sdp_pkg::sdp_bus_req_t bus_req,
  input wire logic [sdp_pkg::DATA_W-1:0] bus_rdata
);
  logic [sdp_pkg::DATA_W-1:0] ctl_word = '0;

  initial bus_req = '0;

  task automatic wr(input logic [sdp_pkg::ADDR_W-1:0] a, input logic [sdp_pkg::DATA_W-1:0] v);
    @(posedge clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= v;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [sdp_pkg::ADDR_W-1:0] a, output logic [sdp_pkg::DATA_W-1:0] v);
    @(posedge clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 v = bus_rdata;
  endtask : rd

  function automatic longint ideal(longint h, longint l, longint r, longint m, bit s, longint w);
    longint den;
    den = (m + 1) * 16384;
    if (!s) return (h * h - l * l) * (r + 1) / den;
    if (w == 0) return 2 * (h * h - l * l) * (r + 1) / den;
    return (h + l) * (h - l + 2 * w) * (r + 1) / den;
  endfunction : ideal

  // Only pre-registers are written; the working copy follows at start
  task automatic load(input int lo, hi, ac, dc, mg, sd, aw, dw, ctl, fd);
    ctl_word = 32'(ctl) << 4;
    if (ctl[0]) ctl_word[sdp_pkg::CTRL_TRI] = 1'b1;
    wr(sdp_pkg::OFS_CTRL, ctl_word);
    wr(sdp_pkg::OFS_FEED, 32'(fd));
    wr(sdp_pkg::OFS_LOW, 32'(lo));
    wr(sdp_pkg::OFS_HIGH, 32'(hi));
    wr(sdp_pkg::OFS_ACC, 32'(ac));
    wr(sdp_pkg::OFS_DEC, 32'(dc));
    wr(sdp_pkg::OFS_MAG, 32'(mg));
    wr(sdp_pkg::OFS_SDP, 32'(sd));
    wr(sdp_pkg::OFS_ASW, 32'(aw));
    wr(sdp_pkg::OFS_DSW, 32'(dw));
  endtask : load

  task automatic start();
    wr(sdp_pkg::OFS_CTRL, ctl_word | 32'h0000_0001);
  endtask : start
endmodule : sdp_host_model

// *** sdp_profile_tb_top.sv ***
// Self-checking testbench of the slow-down and S-curve profile block
`timescale 1ns/10ps
module sdp_profile_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  sdp_pkg::sdp_bus_req_t bus_req;
  logic [sdp_pkg::DATA_W-1:0] bus_rdata;
  logic pulse_out;
  logic busy;
  logic [sdp_pkg::DATA_W-1:0] d;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  int pcount = 0;
  int base = 0;
  int first_t = 0;
  int last_t = 0;
  int k_dec, t_acc, t_dec, tail, k0, t0, t1, la, ld, fa, fdc, pa, pd, id;
  logic [7:0] ra [8] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h3c, 8'h28};
  logic [31:0] rv [8] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 32'h0000_0000,
                          32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  int st [3] = '{8192, 8192, 16383};
  int mg [3] = '{1, 3, 1};
  int slo [3] = '{76, 152, 38};
  int shi [3] = '{76, 152, 39};

  always #2 clk = ~clk;

  sdp_profile dut_u (
    .clk(clk),
    .reset(reset),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .pulse_out(pulse_out),
    .busy(busy)
  );

  sdp_host_model host_u (
    .clk(clk),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata)
  );

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pulse_out === 1'b1) begin
      if (pcount == base) first_t <= cyc;
      pcount <= pcount + 1;
      last_t <= cyc;
    end
  end

  task automatic test_done();
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  // Status is polled every second cycle; pulses are never closer than two
  task automatic run(input int lo, hi, ac, dc, m, sd, aw, dw, ctl, fd);
    int n;
    int ph;
    host_u.load(lo, hi, ac, dc, m, sd, aw, dw, ctl, fd);
    k_dec = -1;
    t_acc = 0;
    t_dec = 0;
    tail = 0;
    n = 0;
    base = pcount;
    host_u.start();
    do begin
      host_u.rd(sdp_pkg::OFS_STAT, d);
      ph = int'(d[6:4]);
      if (ph == 1) t_acc += 2;
      if (ph == 3 && k_dec < 0) k_dec = pcount - base;
      if (ph == 3) t_dec += 2;
      if (ph == 4) tail = 1;
      n++;
    end while (d[0] !== 1'b0 && n < 20000);
    if (n >= 20000) begin
      mismatches++;
      test_done();
    end
    repeat (2) @(posedge clk);
  endtask : run

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    host_u.wr(sdp_pkg::OFS_STAT, 32'hffff_ffff);
    for (int i = 0; i < 8; i++) begin
      host_u.rd(ra[i], d);
      chk_val(d, rv[i]);
    end
    // Constant rate: start lands in cruise, zero manual point never slows
    for (int i = 0; i < 3; i++) begin
      run(st[i], st[i], 1, 0, mg[i], 0, 0, 0, 5, 20);
      chk_rng(last_t - first_t, slo[i], shi[i]);
    end
    run(4096, 4160, 1, 0, 1, 20, 0, 0, 5, 200);
    chk_rng(k_dec, 181, 181);
    id = int'(host_u.ideal(4160, 4096, 1, 1, 1'b0, 0));
    run(4096, 4160, 1, 0, 1, id + 28, 0, 0, 5, 200);
    chk_rng(tail, 1, 1);
    t0 = t_dec;
    run(4096, 4160, 1, 1, 1, id + 28, 0, 0, 5, 200);
    t1 = t_dec;
    chk_rng(t0, t1, t1);
    run(4096, 4160, 1, 3, 1, id + 28, 0, 0, 5, 200);
    chk_rng(t_dec, t1 + 1, 100000);
    run(4096, 4160, 1, 0, 1, id - 22, 0, 0, 5, 200);
    chk_rng(tail, 0, 0);
    // Automatic point: offsets shift the start pulse one for one
    run(4096, 4160, 1, 0, 1, 0, 0, 0, 4, 200);
    k0 = k_dec;
    run(4096, 4160, 1, 0, 1, 8, 0, 0, 4, 200);
    chk_rng(k_dec, k0 - 8, k0 - 8);
    chk_rng(tail, 1, 1);
    run(4096, 4160, 1, 0, 1, 32'h00ff_fff8, 0, 0, 4, 200);
    chk_rng(k_dec, k0 + 8, k0 + 8);
    chk_rng(tail, 0, 0);
    // Linear against full and partial S ramps
    run(4096, 4160, 1, 0, 1, 150, 0, 0, 5, 300);
    la = t_acc;
    ld = t_dec;
    run(4096, 4160, 1, 0, 1, 150, 0, 0, 7, 300);
    fa = t_acc;
    fdc = t_dec;
    chk_rng(fa, la + 1, 3 * la);
    chk_rng(fdc, ld + 1, 3 * ld);
    run(4096, 4160, 1, 0, 1, 150, 8, 8, 7, 300);
    pa = t_acc;
    pd = t_dec;
    chk_rng(pa, la + 1, fa - 1);
    chk_rng(pd, ld + 1, fdc - 1);
    // Manual points around the S-curve ideal: above gives a tail, below none
    id = int'(host_u.ideal(4160, 4096, 1, 1, 1'b1, 0));
    run(4096, 4160, 1, 0, 1, id + 28, 0, 0, 7, 200);
    chk_rng(tail, 1, 1);
    run(4096, 4160, 1, 0, 1, id - 22, 0, 0, 7, 200);
    chk_rng(tail, 0, 0);
    id = int'(host_u.ideal(4160, 4096, 1, 1, 1'b1, 8));
    run(4096, 4160, 1, 0, 1, id + 28, 8, 8, 7, 200);
    chk_rng(tail, 1, 1);
    run(4096, 4160, 1, 0, 1, id - 22, 8, 8, 7, 200);
    chk_rng(tail, 0, 0);
    chk_val({31'h0000_0000, busy}, 32'h0000_0000);
    test_done();
  end
endmodule : sdp_profile_tb_top
